// File: logic/ispbc_core.sv
// Purpose: isp control, forced loader boot and security bits behind an AXI4-Lite slave
// Assumes: aclk 50 MHz, aresetn synchronous active low marks power-on reset
// Notes:   boot pins pass two flip-flops; all outputs registered
// Contract
// - control bit 4 enables the auxiliary RAM; zero disables it.
// - control bit 1 picks loader bank; set: loader in 4 KB, 32KB target.
// - with bit 0 set, programming mode entered only after idle then wake.
// - with bit 0 clear, flash is read-only; erase and program refused.
// - power-on reset without forced boot starts from application bank.
// - boot from loader when both boot pins low, or alternate pin low.
// - security register reachable only in programming mode at top loader address.
// - security bits cleared to zero return to one only by erase-all or by aresetn.
// - lock bit zero blocks access to rom and security register.
// - inhibit zero: table reads from external code reach only external memory.
// - table reads from internal code always reach internal and external memory.
// - inhibit one: no restriction on table reads.
// - encryption enabled encodes port 0 data; only chip erase or aresetn disables it.
// - oscillator gain bit zero halves oscillator amplifier gain.
// - unlock values in sequence make control writable; other value closes it.
// - bits 0, 1 and 7 set together cause a software reset.
`include "ispbc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ispbc_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        boot_select_low,
  input  wire logic        boot_select_high,
  input  wire logic        boot_select_alt,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_wake,
  input  wire logic        fetch_internal,
  output var  logic        aux_ram_enable,
  output var  logic        boot_from_loader,
  output var  logic        loader_bank_is_small,
  output var  logic        prog_mode,
  output var  logic        cpu_reset_req,
  output var  logic        table_read_internal_ok,
  output var  logic        port0_encrypt,
  output var  logic        osc_half_gain
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  always_ff @(posedge aclk) begin
    // no reset: the pin levels are settled when reset lets go and the boot latch reads them
    pin_meta_reg <= {boot_select_alt, boot_select_high, boot_select_low};
    pin_sync_reg <= pin_meta_reg;
  end
  // ==========================================================
  // state registers
  ispbc_pkg::ispbc_ctl_type  ctl_reg, ctl_next;
  ispbc_pkg::ispbc_mode_type mode_reg, mode_next;
  logic [7:0] sec_reg, sec_next;
  logic       unlk_first_reg, unlk_first_next;
  logic       unlk_open_reg, unlk_open_next;
  logic       boot_pend_reg, boot_pend_next;
  logic       swrst_reg, swrst_next;
  logic       aw_ok_reg, aw_ok_next;
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic       w_ok_reg, w_ok_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic       bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic       rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [1:0] acc_reg, acc_next;
  logic       wr_go;
  logic       rd_go;
  logic       sec_open;
  logic [7:0] wbyte;
  always_comb begin
    wr_go = aw_ok_reg && w_ok_reg && !bvalid_reg;
    rd_go = s_axi_arvalid && s_axi_arready;
    wbyte = w_data_reg[7:0];
    sec_open = (mode_reg == ispbc_pkg::ISPBC_PROG) && sec_reg[`ISPBC_SEC_LOCK];
    ctl_next = ctl_reg;
    mode_next = mode_reg;
    sec_next = sec_reg;
    unlk_first_next = unlk_first_reg;
    unlk_open_next = unlk_open_reg;
    boot_pend_next = 1'b0;
    swrst_next = 1'b0;
    acc_next = 2'h0;
    aw_ok_next = aw_ok_reg;
    aw_addr_next = aw_addr_reg;
    w_ok_next = w_ok_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (boot_pend_reg) begin
      ctl_next.forced_loader_boot = (!pin_sync_reg[0] && !pin_sync_reg[1]) || !pin_sync_reg[2];
    end
    case (mode_reg)
      ispbc_pkg::ISPBC_RUN: begin
        if (ctl_reg.rom_program_enable && cpu_idle) begin
          mode_next = ispbc_pkg::ISPBC_IDLE_ARMED;
        end
      end
      ispbc_pkg::ISPBC_IDLE_ARMED: begin
        if (!ctl_reg.rom_program_enable) begin
          mode_next = ispbc_pkg::ISPBC_RUN;
        end else if (cpu_wake) begin
          mode_next = ispbc_pkg::ISPBC_PROG;
        end
      end
      ispbc_pkg::ISPBC_PROG: begin
        if (!ctl_reg.rom_program_enable) begin
          mode_next = ispbc_pkg::ISPBC_RUN;
        end
      end
      default: mode_next = ispbc_pkg::ISPBC_RUN;
    endcase
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_ok_next = 1'b0;
      w_ok_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `ISPBC_RESP_OKAY;
      case (aw_addr_reg)
        `ISPBC_OFF_CONTROL: begin
          if (w_strb_reg[0] && unlk_open_reg) begin
            ctl_next.aux_ram_enable = wbyte[`ISPBC_CTL_AUX_RAM];
            ctl_next.loader_location_select = wbyte[`ISPBC_CTL_LOADER_SEL];
            ctl_next.rom_program_enable = wbyte[`ISPBC_CTL_PROG_EN];
            swrst_next = wbyte[`ISPBC_CTL_SW_RESET] && wbyte[`ISPBC_CTL_LOADER_SEL]
                         && wbyte[`ISPBC_CTL_PROG_EN];
          end
        end
        `ISPBC_OFF_UNLOCK: begin
          if (w_strb_reg[0]) begin
            unlk_first_next = (wbyte == `ISPBC_UNLOCK_FIRST);
            unlk_open_next = unlk_first_reg && (wbyte == `ISPBC_UNLOCK_SECOND);
          end
        end
        `ISPBC_OFF_SECURITY: begin
          if (!sec_open) begin
            bresp_next = `ISPBC_RESP_SLVERR;
          end else if (w_strb_reg[0]) begin
            sec_next = sec_reg & wbyte;
          end
        end
        `ISPBC_OFF_EVENT: begin
          if (w_strb_reg[0] && wbyte[`ISPBC_EVT_ERASE_ALL]) begin
            if (mode_reg == ispbc_pkg::ISPBC_PROG) begin
              sec_next = `ISPBC_SEC_ERASED;
            end else begin
              bresp_next = `ISPBC_RESP_SLVERR;
            end
          end
        end
        `ISPBC_OFF_ACCESS: begin
          if (w_strb_reg[0] && (mode_reg == ispbc_pkg::ISPBC_PROG) && sec_reg[`ISPBC_SEC_LOCK]) begin
            acc_next = wbyte[1:0];
          end else if (w_strb_reg[0] && (wbyte[1:0] != 2'h0)) begin
            bresp_next = `ISPBC_RESP_SLVERR;
          end
        end
        default: bresp_next = `ISPBC_RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rvalid_next = 1'b1;
      rresp_next = `ISPBC_RESP_OKAY;
      rdata_next = 32'h0;
      case (s_axi_araddr)
        `ISPBC_OFF_CONTROL: begin
          rdata_next[`ISPBC_CTL_SW_RESET] = ctl_reg.forced_loader_boot;
          rdata_next[`ISPBC_CTL_AUX_RAM] = ctl_reg.aux_ram_enable;
          rdata_next[`ISPBC_CTL_LOADER_SEL] = ctl_reg.loader_location_select;
          rdata_next[`ISPBC_CTL_PROG_EN] = ctl_reg.rom_program_enable;
        end
        `ISPBC_OFF_UNLOCK: rdata_next[0] = unlk_open_reg;
        `ISPBC_OFF_STATUS: rdata_next[3:0] = {ctl_reg.forced_loader_boot, mode_reg == ispbc_pkg::ISPBC_PROG,
                                              mode_reg == ispbc_pkg::ISPBC_IDLE_ARMED, unlk_open_reg};
        `ISPBC_OFF_SECURITY: begin
          if (sec_open) begin
            rdata_next[7:0] = sec_reg;
          end else begin
            rresp_next = `ISPBC_RESP_SLVERR;
          end
        end
        `ISPBC_OFF_EVENT: rdata_next = 32'h0;
        `ISPBC_OFF_ACCESS: rdata_next[1:0] = acc_reg;
        default: rresp_next = `ISPBC_RESP_SLVERR;
      endcase
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn || swrst_reg) begin
      ctl_reg <= '0;
      mode_reg <= ispbc_pkg::ISPBC_RUN;
      unlk_first_reg <= 1'b0;
      unlk_open_reg <= 1'b0;
      boot_pend_reg <= 1'b1;
      swrst_reg <= 1'b0;
      acc_reg <= 2'h0;
    end else begin
      ctl_reg <= ctl_next;
      mode_reg <= mode_next;
      unlk_first_reg <= unlk_first_next;
      unlk_open_reg <= unlk_open_next;
      boot_pend_reg <= boot_pend_next;
      swrst_reg <= swrst_next;
      acc_reg <= acc_next;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_reg <= `ISPBC_SEC_ERASED;
      aw_ok_reg <= 1'b0;
      aw_addr_reg <= 12'h0;
      w_ok_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end else begin
      sec_reg <= sec_next;
      aw_ok_reg <= aw_ok_next;
      aw_addr_reg <= aw_addr_next;
      w_ok_reg <= w_ok_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end
  // ==========================================================
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      aux_ram_enable <= 1'b0;
      boot_from_loader <= 1'b0;
      loader_bank_is_small <= 1'b0;
      prog_mode <= 1'b0;
      cpu_reset_req <= 1'b0;
      table_read_internal_ok <= 1'b0;
      port0_encrypt <= 1'b0;
      osc_half_gain <= 1'b0;
    end else begin
      s_axi_awready <= !aw_ok_next;
      s_axi_wready <= !w_ok_next;
      s_axi_arready <= !rvalid_next;
      aux_ram_enable <= ctl_next.aux_ram_enable;
      boot_from_loader <= ctl_next.forced_loader_boot;
      loader_bank_is_small <= ctl_next.loader_location_select;
      prog_mode <= (mode_next == ispbc_pkg::ISPBC_PROG);
      cpu_reset_req <= swrst_next;
      table_read_internal_ok <= fetch_internal || sec_next[`ISPBC_SEC_TBL_INH];
      port0_encrypt <= !sec_next[`ISPBC_SEC_ENCRYPT];
      osc_half_gain <= !sec_next[`ISPBC_SEC_OSC_GAIN];
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // ==========================================================
  // assertions
  a_prog_needs_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(prog_mode) |-> $past(mode_reg == ispbc_pkg::ISPBC_IDLE_ARMED))
    else $error("programming mode entered without idle wake");
  a_refuse_no_prog: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_reg != ispbc_pkg::ISPBC_PROG) |=> (acc_reg == 2'h0))
    else $error("flash access granted outside programming mode");
  a_sec_one_way: assert property (@(posedge aclk) disable iff (!aresetn)
    (aw_addr_reg != `ISPBC_OFF_EVENT) |=> ((sec_reg & ~$past(sec_reg)) == 8'h0) || $past(!wr_go))
    else $error("security bit returned to one without erase-all");
  a_lock_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sec_reg[`ISPBC_SEC_LOCK] && rd_go && s_axi_araddr == `ISPBC_OFF_SECURITY)
    |=> (s_axi_rresp == `ISPBC_RESP_SLVERR))
    else $error("locked security register was readable");
  a_table_rule: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sec_reg[`ISPBC_SEC_TBL_INH] && !fetch_internal) |=> (!table_read_internal_ok || sec_reg[`ISPBC_SEC_TBL_INH]))
    else $error("external table read reached internal code");
  a_table_internal: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_internal |=> table_read_internal_ok)
    else $error("internal table read blocked");
  a_sw_reset_fires: assert property (@(posedge aclk) disable iff (!aresetn)
    cpu_reset_req |=> (ctl_reg == '0) ##1 boot_pend_reg == 1'b0)
    else $error("software reset did not clear control");
  a_unlock_needed: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && aw_addr_reg == `ISPBC_OFF_CONTROL && !unlk_open_reg && !swrst_reg) |=> $stable(ctl_reg))
    else $error("control written while closed");
endmodule
`default_nettype wire

// File: logic/ispbc_map.svh
// Purpose: register offsets, field positions and reset values of the isp boot/protection block
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef ISPBC_MAP_SVH
`define ISPBC_MAP_SVH
// ==========================================================
// register offsets
`define ISPBC_OFF_CONTROL    12'h000
`define ISPBC_OFF_UNLOCK     12'h004
`define ISPBC_OFF_STATUS     12'h008
`define ISPBC_OFF_SECURITY   12'h00c
`define ISPBC_OFF_EVENT      12'h010
`define ISPBC_OFF_ACCESS     12'h014
// ==========================================================
// control fields
`define ISPBC_CTL_PROG_EN    0
`define ISPBC_CTL_LOADER_SEL 1
`define ISPBC_CTL_AUX_RAM    4
`define ISPBC_CTL_SW_RESET   7
`define ISPBC_CTL_WMASK      8'h13
`define ISPBC_CTL_RESET      8'h00
// ==========================================================
// unlock values
`define ISPBC_UNLOCK_FIRST   8'h87
`define ISPBC_UNLOCK_SECOND  8'h59
// ==========================================================
// security fields (one-time, erased value ones)
`define ISPBC_SEC_LOCK       0
`define ISPBC_SEC_TBL_INH    1
`define ISPBC_SEC_ENCRYPT    2
`define ISPBC_SEC_OSC_GAIN   7
`define ISPBC_SEC_ERASED     8'hff
`define ISPBC_SEC_ADDR       16'hffff
// ==========================================================
// event register fields
`define ISPBC_EVT_IDLE       0
`define ISPBC_EVT_WAKE       1
`define ISPBC_EVT_ERASE_ALL  2
// ==========================================================
// access register fields
`define ISPBC_ACC_ERASE      0
`define ISPBC_ACC_PROGRAM    1
`define ISPBC_ACC_TARGET     2
// ==========================================================
// axi responses
`define ISPBC_RESP_OKAY      2'b00
`define ISPBC_RESP_SLVERR    2'b10
`endif

// File: logic/ispbc_pkg.sv
// Purpose: types of the isp boot/protection block
// Assumes: used with ispbc_map.svh
// Notes:   nothing is imported
package ispbc_pkg;
  typedef enum logic [1:0] {
    ISPBC_RUN,
    ISPBC_IDLE_ARMED,
    ISPBC_PROG
  } ispbc_mode_type;
  typedef struct packed {
    logic aux_ram_enable;
    logic loader_location_select;
    logic rom_program_enable;
    logic forced_loader_boot;
  } ispbc_ctl_type;
  typedef struct packed {
    logic lock_n;
    logic tbl_inhibit_n;
    logic encrypt_n;
    logic osc_gain_n;
  } ispbc_sec_type;
endpackage

// File: testbench/test_isp_boot_and_code_protection.sv
// Purpose: self-checking bench of ispbc_core
// Assumes: aclk 50 MHz, aresetn synchronous active low
// Notes:   random control data from an lfsr; outputs packed for compare
`include "ispbc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module test_isp_boot_and_code_protection;
  // ==========================================================
  // signals
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, lfsr = 32'd89374;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        sel_low = 1'b1, sel_high = 1'b1, sel_alt = 1'b1;
  logic        idle = 1'b0, wake = 1'b0, fetch_int = 1'b0;
  logic        aux, boot_ldr, small_bank, prog, rst_req, tbl_ok, enc, half_gain;
  int          fails = 0, tests_run = 0, cycles = 0, pulses = 0;
  logic [31:0] d;
  logic        e;
  ispbc_core u_ispbc_core (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .boot_select_low(sel_low), .boot_select_high(sel_high), .boot_select_alt(sel_alt),
    .cpu_idle(idle), .cpu_wake(wake), .fetch_internal(fetch_int),
    .aux_ram_enable(aux), .boot_from_loader(boot_ldr), .loader_bank_is_small(small_bank),
    .prog_mode(prog), .cpu_reset_req(rst_req), .table_read_internal_ok(tbl_ok),
    .port0_encrypt(enc), .osc_half_gain(half_gain)
  );
  // ==========================================================
  // clock, watchdog, reset pulse counter
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (rst_req === 1'b1) pulses++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] outs();
    return {aux, boot_ldr, small_bank, prog, tbl_ok, enc, half_gain};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] exp);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, exp}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] exp, input logic [31:0] m, input logic [31:0] v);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    chk("rresp", {30'h0, exp}, {30'h0, rresp});
    if (exp == `ISPBC_RESP_OKAY) chk("rdata", v & m, rdata & m);
  endtask
  task automatic open_ctl();
    wr(`ISPBC_OFF_UNLOCK, 32'h87, `ISPBC_RESP_OKAY);
    wr(`ISPBC_OFF_UNLOCK, 32'h59, `ISPBC_RESP_OKAY);
  endtask
  task automatic hard_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    hard_reset();
    chk("outs_reset", 32'h04, {25'h0, outs()});
    rd(`ISPBC_OFF_CONTROL, `ISPBC_RESP_OKAY, 32'hff, 32'h00);
    rd(12'h020, `ISPBC_RESP_SLVERR, 32'h0, 32'h0);
    wr(`ISPBC_OFF_CONTROL, 32'h10, `ISPBC_RESP_OKAY);
    rd(`ISPBC_OFF_CONTROL, `ISPBC_RESP_OKAY, 32'hff, 32'h00);
    // control bits: corner values then random ones
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      d = (i == 0) ? 32'h0c : (i == 1) ? 32'h10 : (i == 2) ? 32'h02 : lfsr;
      d[7] = 1'b0;
      open_ctl();
      wr(`ISPBC_OFF_CONTROL, d, `ISPBC_RESP_OKAY);
      rd(`ISPBC_OFF_CONTROL, `ISPBC_RESP_OKAY, 32'hffffffff, d & 32'h13);
      settle();
      chk("aux_ram", {31'h0, d[4]}, {31'h0, aux});
      chk("small_bank", {31'h0, d[1]}, {31'h0, small_bank});
      chk("prog_idle_low", 32'h0, {31'h0, prog});
    end
    open_ctl();
    wr(`ISPBC_OFF_CONTROL, 32'h00, `ISPBC_RESP_OKAY);
    wr(`ISPBC_OFF_UNLOCK, 32'h87, `ISPBC_RESP_OKAY);
    wr(`ISPBC_OFF_UNLOCK, 32'h11, `ISPBC_RESP_OKAY);
    wr(`ISPBC_OFF_CONTROL, 32'h10, `ISPBC_RESP_OKAY);
    rd(`ISPBC_OFF_CONTROL, `ISPBC_RESP_OKAY, 32'hff, 32'h00);
    rd(`ISPBC_OFF_UNLOCK, `ISPBC_RESP_OKAY, 32'h01, 32'h00);
    wr(`ISPBC_OFF_ACCESS, 32'h01, `ISPBC_RESP_SLVERR);
    wr(`ISPBC_OFF_ACCESS, 32'h02, `ISPBC_RESP_SLVERR);
    rd(`ISPBC_OFF_SECURITY, `ISPBC_RESP_SLVERR, 32'h0, 32'h0);
    // programming mode entry needs idle then wake
    open_ctl();
    wr(`ISPBC_OFF_CONTROL, 32'h01, `ISPBC_RESP_OKAY);
    @(posedge aclk) wake <= 1'b1;
    @(posedge aclk) wake <= 1'b0;
    settle();
    chk("prog_wake_only", 32'h0, {31'h0, prog});
    @(posedge aclk) idle <= 1'b1;
    settle();
    chk("prog_idle_only", 32'h0, {31'h0, prog});
    rd(`ISPBC_OFF_STATUS, `ISPBC_RESP_OKAY, 32'h0f, 32'h03);
    @(posedge aclk) wake <= 1'b1;
    @(posedge aclk) wake <= 1'b0;
    idle <= 1'b0;
    settle();
    chk("prog_entered", 32'h1, {31'h0, prog});
    rd(`ISPBC_OFF_STATUS, `ISPBC_RESP_OKAY, 32'h0f, 32'h05);
    rd(`ISPBC_OFF_SECURITY, `ISPBC_RESP_OKAY, 32'h87, 32'h87);
    wr(`ISPBC_OFF_ACCESS, 32'h01, `ISPBC_RESP_OKAY);
    wr(`ISPBC_OFF_SECURITY, 32'hfd, `ISPBC_RESP_OKAY);
    settle();
    chk("tbl_external", 32'h0, {31'h0, tbl_ok});
    @(posedge aclk) fetch_int <= 1'b1;
    settle();
    chk("tbl_internal", 32'h1, {31'h0, tbl_ok});
    @(posedge aclk) fetch_int <= 1'b0;
    wr(`ISPBC_OFF_SECURITY, 32'hff, `ISPBC_RESP_OKAY);
    rd(`ISPBC_OFF_SECURITY, `ISPBC_RESP_OKAY, 32'h87, 32'h85);
    wr(`ISPBC_OFF_SECURITY, 32'h7b, `ISPBC_RESP_OKAY);
    settle();
    chk("encrypt_gain", 32'h3, {30'h0, enc, half_gain});
    wr(`ISPBC_OFF_EVENT, 32'h04, `ISPBC_RESP_OKAY);
    settle();
    rd(`ISPBC_OFF_SECURITY, `ISPBC_RESP_OKAY, 32'h87, 32'h87);
    chk("erased_outs", 32'h4, {29'h0, tbl_ok, enc, half_gain});
    wr(`ISPBC_OFF_SECURITY, 32'hfe, `ISPBC_RESP_OKAY);
    rd(`ISPBC_OFF_SECURITY, `ISPBC_RESP_SLVERR, 32'h0, 32'h0);
    wr(`ISPBC_OFF_ACCESS, 32'h01, `ISPBC_RESP_SLVERR);
    // software reset
    pulses = 0;
    open_ctl();
    wr(`ISPBC_OFF_CONTROL, 32'h83, `ISPBC_RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk("reset_pulses", 32'h1, pulses);
    rd(`ISPBC_OFF_CONTROL, `ISPBC_RESP_OKAY, 32'h13, 32'h00);
    chk("prog_after_swrst", 32'h0, {31'h0, prog});
    // forced loader boot over every pin combination
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk) {sel_alt, sel_high, sel_low} <= i[2:0];
      e = (i[1:0] == 2'b00) || !i[2];
      hard_reset();
      chk("boot_loader", {31'h0, e}, {31'h0, boot_ldr});
      rd(`ISPBC_OFF_CONTROL, `ISPBC_RESP_OKAY, 32'h80, {24'h0, e, 7'h0});
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
